// *** tb/scp_host_model.sv ***
// Host side of the serial link: clock, select, data in, data out capture
`timescale 1ns/1ns
module scp_host_model
(
    output logic link_clk,
    output logic sel_n,
    output logic serial_port_in,
    input wire logic serial_port_out
);
    logic [4:0] got;
    event got_ev;
    initial
    begin
        link_clk = 1'b0;
        // Late update so the port sees a rising select and clears its shifter
        sel_n <= 1'b1;
        serial_port_in = 1'b1;
    end
    // Frame clocks nbits edges with select low; a short nbits cuts the frame early
    task automatic frame(input logic rw, input logic [3:0] addr, input logic [1:0] pad,
        input logic [4:0] data, input int nbits, input logic dc);
        logic [12:0] bits;
        bits = {data, dc, pad, addr, rw};
        sel_n = 1'b0;
        for (int k = 0; k < nbits; k++)
        begin
            serial_port_in = bits[k];
            #7 link_clk = 1'b1;
            if (k >= 8)
                got[k-8] = serial_port_out;
            #8 link_clk = 1'b0;
        end
        #7 sel_n = 1'b1;
        // Released line shows the inverse of its last bit
        serial_port_in = ~serial_port_in;
        // Select stays high for a while so the next frame starts clean
        #8;
        if (rw && nbits == 13)
            ->got_ev;
    endtask
    task automatic stray(input int n);
        for (int k = 0; k < n; k++)
        begin
            serial_port_in = ~serial_port_in;
            #7 link_clk = 1'b1;
            #8 link_clk = 1'b0;
        end
    endtask
endmodule

// *** tb/scp_serial_port_properties.sv ***
// Checker of the serial command port, bound to its ports
`timescale 1ns/1ns
module scp_serial_port_properties
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic sel_n,
    input wire logic serial_port_in,
    input wire logic serial_port_out_oe_n,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire scp_pkg::scp_loop_t loop_mode_reg,
    input wire logic pad_err_reg
);
    // Edge count and direction of the current frame; cleared with the select like the port
    logic [3:0] edges_reg;
    logic rw_reg;
    always_ff @(posedge link_clk or posedge sel_n)
    begin
        if (sel_n)
        begin
            edges_reg <= 4'h0;
            rw_reg <= 1'b0;
        end
        else
        begin
            if (edges_reg == 4'h0)
                rw_reg <= serial_port_in;
            if (edges_reg != 4'hf)
                edges_reg <= edges_reg + 4'h1;
        end
    end
    loop_wr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bus_wr && bus_addr == 8'h00 |=> ##1 loop_mode_reg == $past(bus_wdata[1:0], 2))
        else $error("loop mode does not follow the written bits");
    rd_loop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bus_rd && bus_addr == 8'h00 && !$past(bus_wr) && !$past(bus_wr, 2)
        |=> bus_rdata[31:4] == 28'h000_0000 && bus_rdata[3:2] == bus_rdata[1:0])
        else $error("decoded mode differs from select bits");
    rd_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(bus_rd) |-> bus_rdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");
    rd_regs_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bus_rd && bus_addr[7:4] == 4'h1 |=> bus_rdata[31:5] == 27'h000_0000)
        else $error("command register wider than five bits");
    oe_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sel_n && $past(sel_n) |-> serial_port_out_oe_n)
        else $error("output driven while not selected");
    hdr_quiet_a: assert property (@(posedge link_clk) disable iff (sel_n)
        edges_reg < 4'h8 || !rw_reg |-> serial_port_out_oe_n)
        else $error("output driven in header or write");
    rd_drive_a: assert property (@(posedge link_clk) disable iff (sel_n)
        rw_reg && edges_reg >= 4'h8 |-> !serial_port_out_oe_n)
        else $error("read data not driven");
    pad_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $past(pad_err_reg) |-> pad_err_reg)
        else $error("pad error flag dropped");
endmodule

bind scp_serial_port scp_serial_port_properties scp_serial_port_properties_i(
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link_clk(link_clk), .sel_n(sel_n),
    .serial_port_in(serial_port_in), .serial_port_out_oe_n(serial_port_out_oe_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .loop_mode_reg(loop_mode_reg), .pad_err_reg(pad_err_reg));

// *** tb/scp_serial_port_tb.sv ***
// Self-checking bench of the serial command port
`timescale 1ns/1ns
module scp_serial_port_tb;
    logic clk_sys = 1'b0;
    logic sys_rst;
    logic link_clk, sel_n, serial_port_in, serial_port_out, serial_port_out_oe_n;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    scp_pkg::scp_loop_t loop_mode_reg;
    logic pad_err_reg;
    logic [31:0] seed = 32'h0000_3113;
    logic [31:0] bus_q[$];
    logic [4:0] ser_q[$];
    logic pend = 1'b0;
    int fails = 0;
    int compares = 0;
    logic [4:0] d4, d9;
    logic [7:0] probe_addr [5] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h14};
    always #20 clk_sys = ~clk_sys;
    scp_serial_port scp_serial_port_i(.clk_sys(clk_sys), .sys_rst(sys_rst),
        .link_clk(link_clk), .sel_n(sel_n), .serial_port_in(serial_port_in),
        .serial_port_out(serial_port_out), .serial_port_out_oe_n(serial_port_out_oe_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .loop_mode_reg(loop_mode_reg), .pad_err_reg(pad_err_reg));
    scp_host_model scp_host_model_i(.link_clk(link_clk), .sel_n(sel_n),
        .serial_port_in(serial_port_in), .serial_port_out(serial_port_out));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_ser(input logic [4:0] got, input logic [4:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: serial read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_wr <= wr;
        bus_rd <= rd;
        bus_addr <= a;
        bus_wdata <= d;
    endtask
    task automatic brd(input logic [7:0] a, input logic [31:0] exp);
        bus_q.push_back(exp);
        bus(1'b0, 1'b1, a, 32'h0000_0000);
    endtask
    task automatic idle;
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    endtask
    task automatic wrap_up;
        if (bus_q.size() + ser_q.size() != 0)
            fails++;
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****************
    // Result watchers
    // ****************
    always @(posedge clk_sys)
    begin
        if (pend)
            cmp(bus_rdata, bus_q.pop_front());
        pend = bus_rd;
    end
    always @(scp_host_model_i.got_ev)
        cmp_ser(scp_host_model_i.got, ser_q.pop_front());
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        $display("unexpected at %0t: run did not finish", $time);
        fails++;
        wrap_up();
    end
    // ****************
    // Main sequence
    // ****************
    initial
    begin
        sys_rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (probe_addr[i])
            brd(probe_addr[i], 32'h0000_0000);
        for (int m = 0; m < 4; m++)
        begin
            seed = lfsr(seed);
            bus(1'b1, 1'b0, 8'h00, {seed[31:2], m[1:0]});
            idle();
            idle();
            brd(8'h00, {28'h000_0000, m[1:0], m[1:0]});
        end
        bus(1'b1, 1'b0, 8'h1a, seed);
        brd(8'h1a, {27'h000_0000, seed[4:0]});
        idle();
        seed = lfsr(seed);
        d4 = seed[4:0];
        d9 = seed[9:5];
        scp_host_model_i.frame(1'b0, 4'h4, 2'b00, d4, 13, seed[10]);
        repeat (8) @(posedge clk_sys);
        scp_host_model_i.frame(1'b0, 4'h9, 2'b00, d9, 13, ~seed[10]);
        repeat (8) @(posedge clk_sys);
        brd(8'h14, {27'h000_0000, d4});
        brd(8'h19, {27'h000_0000, d9});
        brd(8'h00, {28'h000_0000, d4[1:0], d4[1:0]});
        brd(8'h01, 32'h0000_0009);
        brd(8'h02, 32'h0000_0002);
        idle();
        ser_q.push_back(d9);
        scp_host_model_i.frame(1'b1, 4'h9, 2'b00, 5'h00, 13, seed[11]);
        ser_q.push_back(d4);
        scp_host_model_i.frame(1'b1, 4'h4, 2'b00, 5'h1f, 13, ~seed[11]);
        // A cut frame and clocks without select must leave everything alone
        scp_host_model_i.frame(1'b0, 4'h9, 2'b00, ~d9, 10, 1'b0);
        scp_host_model_i.stray(16);
        repeat (8) @(posedge clk_sys);
        brd(8'h19, {27'h000_0000, d9});
        brd(8'h02, 32'h0000_0002);
        idle();
        scp_host_model_i.frame(1'b0, 4'h9, 2'b01, d9, 13, 1'b0);
        repeat (8) @(posedge clk_sys);
        brd(8'h01, 32'h0000_0019);
        idle();
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        brd(8'h01, 32'h0000_0000);
        brd(8'h14, 32'h0000_0000);
        brd(8'h1a, 32'h0000_0000);
        idle();
        repeat (3) @(posedge clk_sys);
        wrap_up();
    end
endmodule

// *** verilog/scp_loop_dec.sv ***
// Decoder of the two loop-back select bits into a loop-back mode
`timescale 1ns/1ns
module scp_loop_dec
(
    input wire logic local_loop_sel,
    input wire logic remote_loop_sel,
    output scp_pkg::scp_loop_t mode
);
    always_comb
    begin
        case ({local_loop_sel, remote_loop_sel})
            2'b00: mode = scp_pkg::SCP_LOOP_NONE;
            2'b01: mode = scp_pkg::SCP_LOOP_REMOTE;
            2'b10: mode = scp_pkg::SCP_LOOP_ANALOG;
            default: mode = scp_pkg::SCP_LOOP_DIGITAL;
        endcase
    end
endmodule

// *** verilog/scp_pkg.sv ***
// Package: constants, types and register map of the serial command port
package scp_pkg;
    localparam int HDR_BITS = 8;
    localparam int DATA_BITS = 5;
    localparam int ADDR_BITS = 4;
    localparam int NUM_REGS = 16;
    localparam logic [3:0] CR_LOOP_IDX = 4'h4;
    localparam int LOOP_LOCAL_POS = 1;
    localparam int LOOP_REMOTE_POS = 0;
    localparam logic [4:0] CR_RESET_VAL = 5'h00;
    localparam logic [7:0] SW_ADDR_LOOP = 8'h00;
    localparam logic [7:0] SW_ADDR_LAST = 8'h01;
    localparam logic [7:0] SW_ADDR_COUNT = 8'h02;
    localparam logic [7:0] SW_ADDR_REGS = 8'h10;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        SCP_LOOP_NONE = 2'b00,
        SCP_LOOP_REMOTE = 2'b01,
        SCP_LOOP_ANALOG = 2'b10,
        SCP_LOOP_DIGITAL = 2'b11
    } scp_loop_t;

    typedef enum logic [1:0] {
        SCP_ST_HDR = 2'b00,
        SCP_ST_DATA = 2'b01,
        SCP_ST_DONE = 2'b10
    } scp_state_t;

    // One finished serial write, handed to the system domain
    typedef struct packed {
        logic [3:0] addr;
        logic [4:0] data;
    } scp_wr_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } scp_bus_t;
endpackage

// *** verilog/scp_serial_port.sv ***
// Serial command register port with loop-back mode decode
//
// Overview of operation
// - Local then remote bit select loop-back mode
// - Low select starts transfer; ignore input otherwise
// - Header bits sampled on rising serial clock
// - First bit: one reads, zero writes
// - Next four bits: address, LSB first
// - Address picks the command register accessed
// - Eighth header bit is ignored
`timescale 1ns/1ns
module scp_serial_port
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Serial link, clocked by the host
    input wire logic link_clk,
    input wire logic sel_n,
    input wire logic serial_port_in,
    output logic serial_port_out,
    output logic serial_port_out_oe_n,
    // Register port
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    // Loop-back selection to the line side and the sticky pad error flag
    output scp_pkg::scp_loop_t loop_mode_reg,
    output logic pad_err_reg
);
    // ******************************************************
    // Link domain: header and data shifter
    // ******************************************************
    // Select high holds the shifter in reset; it runs only while the host
    // clocks, so a frame cut short is simply dropped.
    scp_pkg::scp_state_t st_reg;
    logic [3:0] bit_cnt_reg;
    logic rnw_reg;
    logic [3:0] addr_reg;
    logic [1:0] pad_reg;
    logic [4:0] wdat_reg;
    logic [4:0] rdat_reg;
    logic wr_tog_reg;
    logic pad_tog_reg;
    scp_pkg::scp_wr_t wr_hold_reg;
    logic [4:0] regs_snap [scp_pkg::NUM_REGS];
    logic out_reg;
    logic oe_n_reg;

    always_ff @(posedge link_clk or posedge sel_n)
    begin
        if (sel_n)
        begin
            st_reg <= scp_pkg::SCP_ST_HDR;
            bit_cnt_reg <= 4'h0;
            rnw_reg <= 1'b0;
            addr_reg <= 4'h0;
            pad_reg <= 2'b00;
            wdat_reg <= 5'h00;
        end
        else
        begin
            case (st_reg)
                scp_pkg::SCP_ST_HDR:
                begin
                    if (bit_cnt_reg == 4'd0)
                    begin
                        rnw_reg <= serial_port_in;
                    end
                    else if (bit_cnt_reg <= 4'd4)
                    begin
                        addr_reg <= {serial_port_in, addr_reg[3:1]};
                    end
                    else if (bit_cnt_reg <= 4'd6)
                    begin
                        pad_reg <= {serial_port_in, pad_reg[1]};
                    end
                    // Bit eight is sampled by nobody
                    if (bit_cnt_reg == 4'(scp_pkg::HDR_BITS - 1))
                    begin
                        bit_cnt_reg <= 4'h0;
                        st_reg <= scp_pkg::SCP_ST_DATA;
                    end
                    else
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                scp_pkg::SCP_ST_DATA:
                begin
                    wdat_reg <= {serial_port_in, wdat_reg[4:1]};
                    if (bit_cnt_reg == 4'(scp_pkg::DATA_BITS - 1))
                    begin
                        st_reg <= scp_pkg::SCP_ST_DONE;
                    end
                    else
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                default:
                begin
                    st_reg <= scp_pkg::SCP_ST_DONE;
                end
            endcase
        end
    end

    // Completion toggles survive the select reset, so each event crosses once.
    // Only the system reset clears them, together with the synchroniser, so no
    // stale toggle looks like a new event; the host keeps the link clock still
    // while the system is in reset.
    always_ff @(posedge link_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_tog_reg <= 1'b0;
            pad_tog_reg <= 1'b0;
            wr_hold_reg <= '0;
        end
        else
        begin
            if (!sel_n && st_reg == scp_pkg::SCP_ST_DATA
                && bit_cnt_reg == 4'(scp_pkg::DATA_BITS - 1) && !rnw_reg)
            begin
                wr_hold_reg <= '{addr: addr_reg, data: {serial_port_in, wdat_reg[4:1]}};
                wr_tog_reg <= ~wr_tog_reg;
            end
            if (!sel_n && st_reg == scp_pkg::SCP_ST_HDR && bit_cnt_reg == 4'd6
                && ({serial_port_in, pad_reg[1]} != 2'b00))
            begin
                pad_tog_reg <= ~pad_tog_reg;
            end
        end
    end

    // Read data launched on the falling edge so the host samples it on rising
    always_ff @(negedge link_clk or posedge sel_n)
    begin
        if (sel_n)
        begin
            out_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            rdat_reg <= 5'h00;
        end
        else if (st_reg == scp_pkg::SCP_ST_DATA && rnw_reg)
        begin
            oe_n_reg <= 1'b0;
            if (bit_cnt_reg == 4'd0)
            begin
                out_reg <= regs_snap[addr_reg][0];
                rdat_reg <= {1'b0, regs_snap[addr_reg][4:1]};
            end
            else
            begin
                out_reg <= rdat_reg[0];
                rdat_reg <= {1'b0, rdat_reg[4:1]};
            end
        end
        else
        begin
            oe_n_reg <= 1'b1;
        end
    end

    assign serial_port_out = out_reg;
    assign serial_port_out_oe_n = oe_n_reg;

    // ******************************************************
    // System domain: register file and bus slave
    // ******************************************************
    logic [4:0] regs [scp_pkg::NUM_REGS];
    logic [1:0] tog_sync;
    logic wr_seen_reg;
    logic pad_seen_reg;
    logic [3:0] last_addr_reg;
    logic [7:0] wr_count_reg;
    logic [31:0] rdata_reg;
    logic ser_wr;
    scp_pkg::scp_loop_t loop_dec;

    scp_sync2 #(.W(2)) u_sync
    (
        .clk(clk_sys),
        .rst(sys_rst),
        .d({wr_tog_reg, pad_tog_reg}),
        .q(tog_sync)
    );

    assign ser_wr = tog_sync[1] ^ wr_seen_reg;

    // Snapshot only changes with the system clock; a serial read racing a
    // write may see either value, which the host cannot distinguish anyway.
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < scp_pkg::NUM_REGS; i++)
        begin
            regs_snap[i] <= regs[i];
        end
    end

    // Hold data is stable for several system cycles before the toggle lands
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < scp_pkg::NUM_REGS; i++)
            begin
                regs[i] <= scp_pkg::CR_RESET_VAL;
            end
            wr_seen_reg <= 1'b0;
            pad_seen_reg <= 1'b0;
            last_addr_reg <= 4'h0;
            wr_count_reg <= 8'h00;
        end
        else
        begin
            pad_seen_reg <= tog_sync[0];
            if (ser_wr)
            begin
                wr_seen_reg <= tog_sync[1];
                regs[wr_hold_reg.addr] <= wr_hold_reg.data;
                last_addr_reg <= wr_hold_reg.addr;
                wr_count_reg <= wr_count_reg + 8'h01;
            end
            else if (bus_wr && bus_addr == scp_pkg::SW_ADDR_LOOP)
            begin
                regs[scp_pkg::CR_LOOP_IDX][1:0] <= bus_wdata[1:0];
            end
            else if (bus_wr && bus_addr >= scp_pkg::SW_ADDR_REGS
                     && bus_addr < scp_pkg::SW_ADDR_REGS + 8'(scp_pkg::NUM_REGS))
            begin
                regs[bus_addr[3:0]] <= bus_wdata[4:0];
            end
        end
    end

    // Pad error stays set until reset: a flag of misbehaving hosts
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pad_err_reg <= 1'b0;
        end
        else if (tog_sync[0] ^ pad_seen_reg)
        begin
            pad_err_reg <= 1'b1;
        end
    end

    scp_loop_dec u_dec
    (
        .local_loop_sel(regs[scp_pkg::CR_LOOP_IDX][scp_pkg::LOOP_LOCAL_POS]),
        .remote_loop_sel(regs[scp_pkg::CR_LOOP_IDX][scp_pkg::LOOP_REMOTE_POS]),
        .mode(loop_dec)
    );

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            loop_mode_reg <= scp_pkg::SCP_LOOP_NONE;
        end
        else
        begin
            loop_mode_reg <= loop_dec;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rdata_reg <= scp_pkg::RD_ZERO;
        end
        else if (bus_rd)
        begin
            if (bus_addr == scp_pkg::SW_ADDR_LOOP)
            begin
                rdata_reg <= {28'h000_0000, 2'(loop_dec), regs[scp_pkg::CR_LOOP_IDX][1:0]};
            end
            else if (bus_addr == scp_pkg::SW_ADDR_LAST)
            begin
                rdata_reg <= {27'h000_0000, pad_err_reg, last_addr_reg};
            end
            else if (bus_addr == scp_pkg::SW_ADDR_COUNT)
            begin
                rdata_reg <= {24'h00_0000, wr_count_reg};
            end
            else if (bus_addr >= scp_pkg::SW_ADDR_REGS
                     && bus_addr < scp_pkg::SW_ADDR_REGS + 8'(scp_pkg::NUM_REGS))
            begin
                rdata_reg <= {27'h000_0000, regs[bus_addr[3:0]]};
            end
            else
            begin
                rdata_reg <= scp_pkg::RD_ZERO;
            end
        end
        else
        begin
            rdata_reg <= scp_pkg::RD_ZERO;
        end
    end

    assign bus_rdata = rdata_reg;
endmodule

// *** verilog/scp_sync2.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ns
module scp_sync2
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
